// ### inc/swing_len_pkg.sv
// Summary of operation
// - Swing output traces triangle around centre
// - Zero swing amplitude means no swing
// - Base select: 0 centre, 1 maximum
// - Centre base: amplitude = centre times percent
// - Maximum base: amplitude = max times percent
// - Jump = amplitude times jump percent, 50%
// - Swing output clamped to frequency limits
// - Swing period equals cycle time setting
// - Rise time = cycle times rise coefficient
// - Length = pulses divided by pulses per metre
// - Length above target drives output 10
// - Input function 28 clears measured length
// - Count pulses on input function 25
// - Final count drives output 8, stops
// - Intermediate count drives output 9
package swing_len_pkg;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SWING_PCT_OFS = 8'h04;
	localparam logic [7:0] JUMP_PCT_OFS = 8'h08;
	localparam logic [7:0] CYCLE_OFS = 8'h0C;
	localparam logic [7:0] RISE_COEF_OFS = 8'h10;
	localparam logic [7:0] TGT_LEN_OFS = 8'h14;
	localparam logic [7:0] MEAS_LEN_OFS = 8'h18;
	localparam logic [7:0] PPM_OFS = 8'h1C;
	localparam logic [7:0] FINAL_CNT_OFS = 8'h20;
	localparam logic [7:0] MID_CNT_OFS = 8'h24;
	localparam logic [7:0] CENTRE_OFS = 8'h28;
	localparam logic [7:0] MAX_FREQ_OFS = 8'h2C;
	localparam logic [7:0] UPPER_OFS = 8'h30;
	localparam logic [7:0] LOWER_OFS = 8'h34;
	localparam logic [7:0] OUT_FREQ_OFS = 8'h38;
	localparam logic [7:0] STATUS_OFS = 8'h3C;
	localparam logic [7:0] COUNT_OFS = 8'h40;
	localparam logic [7:0] DI_FN_OFS = 8'h44;
	localparam logic [7:0] DO_FN_OFS = 8'h48;
	localparam int CTRL_SWING_EN_BIT = 0;
	localparam int CTRL_BASE_BIT = 1;
	localparam int CTRL_LEN_CLR_BIT = 2;
	localparam int CTRL_CNT_CLR_BIT = 3;
	localparam int ST_LEN_BIT = 0;
	localparam int ST_FINAL_BIT = 1;
	localparam int ST_MID_BIT = 2;
	localparam int ST_FALL_BIT = 3;
	localparam logic [15:0] SWING_PCT_RST = 16'h0000;
	localparam logic [15:0] SWING_PCT_MAX = 16'h03E8;
	localparam logic [15:0] JUMP_PCT_RST = 16'h0000;
	localparam logic [15:0] JUMP_PCT_MAX = 16'h01F4;
	localparam logic [15:0] CYCLE_RST = 16'h0064;
	localparam logic [15:0] CYCLE_MAX = 16'h7530;
	localparam logic [15:0] RISE_COEF_RST = 16'h01F4;
	localparam logic [15:0] RISE_COEF_MAX = 16'h03E8;
	localparam logic [15:0] TGT_LEN_RST = 16'h03E8;
	localparam logic [15:0] PPM_RST = 16'h03E8;
	localparam logic [15:0] PPM_MIN = 16'h0001;
	localparam logic [15:0] FINAL_CNT_RST = 16'h03E8;
	localparam logic [15:0] MID_CNT_RST = 16'h03E8;
	localparam logic [15:0] CNT_MIN = 16'h0001;
	localparam logic [15:0] CENTRE_RST = 16'h0000;
	localparam logic [15:0] MAX_FREQ_RST = 16'h1388;
	localparam logic [15:0] UPPER_RST = 16'h1388;
	localparam logic [15:0] LOWER_RST = 16'h0000;
	localparam int PCT_SCALE = 1000;
	localparam int LEN_SCALE = 10;
	localparam int FN_W = 6;
	localparam int NUM_DI = 4;
	localparam int NUM_TERM = NUM_DI + 1;
	localparam int NUM_DO = 4;
	localparam logic [FN_W-1:0] FN_FINAL_REACHED = 6'h08;
	localparam logic [FN_W-1:0] FN_MID_REACHED = 6'h09;
	localparam logic [FN_W-1:0] FN_LEN_REACHED = 6'h0A;
	localparam logic [FN_W-1:0] FN_COUNT_IN = 6'h19;
	localparam logic [FN_W-1:0] FN_LEN_IN = 6'h1B;
	localparam logic [FN_W-1:0] FN_LEN_CLR = 6'h1C;
	localparam int CLK_HZ = 125_000_000;
	localparam int SWING_TICK_MS = 1;
	localparam int MS_PER_CYCLE_UNIT = 100;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * SWING_TICK_MS;
	localparam int MS_W = 24;
endpackage

// ### inc/swing_if.sv
`timescale 1ns/100ps
interface swing_if;
	logic tick;
	logic run;
	logic [23:0] rise_ms;
	logic [23:0] fall_ms;
	logic [23:0] t_ms;
	logic falling;
	logic turn;
	modport ctl(output tick, run, rise_ms, fall_ms,
		input t_ms, falling, turn);
	modport phase(input tick, run, rise_ms, fall_ms,
		output t_ms, falling, turn);
endinterface

// ### logic/swing_phase.sv
`timescale 1ns/100ps
module swing_phase (
	input wire logic pclk,
	input wire logic presetn,
	swing_if.phase sw
);
	logic [23:0] t_q;
	logic fall_q;
	logic turn_q;
	wire [23:0] span = fall_q ? sw.fall_ms : sw.rise_ms;
	wire at_end = ({1'b0, t_q} + 25'h0000001) >= {1'b0, span};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_q <= 24'h000000;
			fall_q <= 1'b0;
			turn_q <= 1'b0;
		end else if (!sw.run) begin
			t_q <= 24'h000000;
			fall_q <= 1'b0;
			turn_q <= 1'b0;
		end else begin
			turn_q <= 1'b0;
			if (sw.tick && at_end) begin
				t_q <= 24'h000000;
				fall_q <= ~fall_q;
				turn_q <= 1'b1;
			end else if (sw.tick) begin
				t_q <= t_q + 24'h000001;
			end
		end
	end

	assign sw.t_ms = t_q;
	assign sw.falling = fall_q;
	assign sw.turn = turn_q;
endmodule

// ### logic/seq_divider.sv
`timescale 1ns/100ps
module seq_divider #(
	parameter int NW = 40,
	parameter int DW = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [NW-1:0] num,
	input wire logic [DW-1:0] den,
	output logic done,
	output logic [NW-1:0] quot
);
	localparam int CW = $clog2(NW + 1);
	logic [NW-1:0] q_q;
	logic [DW:0] r_q;
	logic [CW-1:0] n_q;
	wire [DW:0] trial = {r_q[DW-1:0], q_q[NW-1]};
	wire ge = trial >= {1'b0, den};

	// Restoring, one quotient bit per cycle; zero divisor gives all ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_q <= '0;
			r_q <= '0;
			n_q <= '0;
			done <= 1'b0;
			quot <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				q_q <= num;
				r_q <= '0;
				n_q <= CW'(NW);
			end else if (n_q != '0) begin
				r_q <= ge ? trial - {1'b0, den} : trial;
				q_q <= {q_q[NW-2:0], ge};
				n_q <= n_q - 1'b1;
				if (n_q == CW'(1)) begin
					done <= 1'b1;
					quot <= {q_q[NW-2:0], ge};
				end
			end
		end
	end
endmodule

// ### logic/swing_freq_length_counter.sv
`timescale 1ns/100ps
module swing_freq_length_counter
	import swing_len_pkg::*;
#(
	parameter int MS_TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_DI-1:0] digital_input_terminal,
	input wire logic high_speed_pulse_input,
	output logic [NUM_DO-1:0] do_terminal,
	output logic [15:0] output_frequency
);
	swing_if sw();

	logic swing_en_q;
	logic base_sel_q;
	logic [15:0] swing_pct_q;
	logic [15:0] jump_pct_q;
	logic [15:0] cycle_q;
	logic [15:0] rise_coef_q;
	logic [15:0] tgt_len_q;
	logic [15:0] ppm_q;
	logic [15:0] final_cnt_q;
	logic [15:0] mid_cnt_q;
	logic [15:0] centre_q;
	logic [15:0] max_freq_q;
	logic [15:0] upper_q;
	logic [15:0] lower_q;
	logic [NUM_TERM*FN_W-1:0] di_fn_q;
	logic [NUM_DO*FN_W-1:0] do_fn_q;
	logic [15:0] meas_len_q;
	logic [15:0] cnt_q;
	logic len_reached_q;
	logic final_q;
	logic mid_q;

	// Bus slave: no wait states, pready is a flop
	wire wr_en = psel & penable & pwrite & pready;
	wire setup = psel & ~penable & ~pready;
	wire [15:0] wd = pwdata[15:0];
	wire wr_ctrl = wr_en && paddr == CTRL_OFS;
	wire len_sw_clr = wr_ctrl & pwdata[CTRL_LEN_CLR_BIT];
	wire cnt_sw_clr = wr_ctrl & pwdata[CTRL_CNT_CLR_BIT];
	logic [31:0] rd_d;
	logic hit_d;

	always_comb begin
		rd_d = 32'h00000000;
		hit_d = 1'b1;
		if (paddr == CTRL_OFS)
			rd_d = {30'h00000000, base_sel_q, swing_en_q};
		else if (paddr == SWING_PCT_OFS)
			rd_d = {16'h0000, swing_pct_q};
		else if (paddr == JUMP_PCT_OFS)
			rd_d = {16'h0000, jump_pct_q};
		else if (paddr == CYCLE_OFS)
			rd_d = {16'h0000, cycle_q};
		else if (paddr == RISE_COEF_OFS)
			rd_d = {16'h0000, rise_coef_q};
		else if (paddr == TGT_LEN_OFS)
			rd_d = {16'h0000, tgt_len_q};
		else if (paddr == MEAS_LEN_OFS)
			rd_d = {16'h0000, meas_len_q};
		else if (paddr == PPM_OFS)
			rd_d = {16'h0000, ppm_q};
		else if (paddr == FINAL_CNT_OFS)
			rd_d = {16'h0000, final_cnt_q};
		else if (paddr == MID_CNT_OFS)
			rd_d = {16'h0000, mid_cnt_q};
		else if (paddr == CENTRE_OFS)
			rd_d = {16'h0000, centre_q};
		else if (paddr == MAX_FREQ_OFS)
			rd_d = {16'h0000, max_freq_q};
		else if (paddr == UPPER_OFS)
			rd_d = {16'h0000, upper_q};
		else if (paddr == LOWER_OFS)
			rd_d = {16'h0000, lower_q};
		else if (paddr == OUT_FREQ_OFS)
			rd_d = {16'h0000, output_frequency};
		else if (paddr == STATUS_OFS)
			rd_d = {28'h0000000, sw.falling, mid_q, final_q,
				len_reached_q};
		else if (paddr == COUNT_OFS)
			rd_d = {16'h0000, cnt_q};
		else if (paddr == DI_FN_OFS)
			rd_d = {2'h0, di_fn_q};
		else if (paddr == DO_FN_OFS)
			rd_d = {8'h00, do_fn_q};
		else
			hit_d = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit_d;
			prdata <= (setup && !pwrite) ? rd_d : 32'h00000000;
		end
	end

	// Out-of-range writes saturate so the datapath never sees them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swing_en_q <= 1'b0;
			base_sel_q <= 1'b0;
			swing_pct_q <= SWING_PCT_RST;
			jump_pct_q <= JUMP_PCT_RST;
			cycle_q <= CYCLE_RST;
			rise_coef_q <= RISE_COEF_RST;
			tgt_len_q <= TGT_LEN_RST;
			ppm_q <= PPM_RST;
			final_cnt_q <= FINAL_CNT_RST;
			mid_cnt_q <= MID_CNT_RST;
			centre_q <= CENTRE_RST;
			max_freq_q <= MAX_FREQ_RST;
			upper_q <= UPPER_RST;
			lower_q <= LOWER_RST;
			di_fn_q <= '0;
			do_fn_q <= '0;
		end else if (wr_en) begin
			if (paddr == CTRL_OFS) begin
				swing_en_q <= pwdata[CTRL_SWING_EN_BIT];
				base_sel_q <= pwdata[CTRL_BASE_BIT];
			end else if (paddr == SWING_PCT_OFS)
				swing_pct_q <= wd > SWING_PCT_MAX ? SWING_PCT_MAX : wd;
			else if (paddr == JUMP_PCT_OFS)
				jump_pct_q <= wd > JUMP_PCT_MAX ? JUMP_PCT_MAX : wd;
			else if (paddr == CYCLE_OFS)
				cycle_q <= wd > CYCLE_MAX ? CYCLE_MAX : wd;
			else if (paddr == RISE_COEF_OFS)
				rise_coef_q <= wd > RISE_COEF_MAX ? RISE_COEF_MAX : wd;
			else if (paddr == TGT_LEN_OFS)
				tgt_len_q <= wd;
			else if (paddr == PPM_OFS)
				ppm_q <= wd < PPM_MIN ? PPM_MIN : wd;
			else if (paddr == FINAL_CNT_OFS)
				final_cnt_q <= wd < CNT_MIN ? CNT_MIN : wd;
			else if (paddr == MID_CNT_OFS)
				mid_cnt_q <= wd < CNT_MIN ? CNT_MIN : wd;
			else if (paddr == CENTRE_OFS)
				centre_q <= wd;
			else if (paddr == MAX_FREQ_OFS)
				max_freq_q <= wd;
			else if (paddr == UPPER_OFS)
				upper_q <= wd;
			else if (paddr == LOWER_OFS)
				lower_q <= wd;
			else if (paddr == DI_FN_OFS)
				di_fn_q <= pwdata[NUM_TERM*FN_W-1:0];
			else if (paddr == DO_FN_OFS)
				do_fn_q <= pwdata[NUM_DO*FN_W-1:0];
		end
	end

	// Terminals: index NUM_DI is the high-speed input
	wire [NUM_TERM-1:0] term_raw = {high_speed_pulse_input,
		digital_input_terminal};
	logic [NUM_TERM-1:0] s1_q;
	logic [NUM_TERM-1:0] s2_q;
	logic [NUM_TERM-1:0] s3_q;
	wire [NUM_TERM-1:0] rise = s2_q & ~s3_q;
	logic [NUM_TERM-1:0] cnt_v;
	logic [NUM_TERM-1:0] len_v;
	logic [NUM_TERM-1:0] clr_v;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= term_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
		wire [FN_W-1:0] fn = di_fn_q[i*FN_W +: FN_W];
		assign cnt_v[i] = rise[i] & (fn == FN_COUNT_IN);
		assign len_v[i] = rise[i] & (fn == FN_LEN_IN);
		assign clr_v[i] = s2_q[i] & (fn == FN_LEN_CLR);
	end

	wire cnt_pulse = |cnt_v;
	wire len_pulse = |len_v;
	wire len_clr = (|clr_v) | len_sw_clr;

	// Event counter; a pulse arriving with a clear is kept
	wire [15:0] cnt_base = cnt_sw_clr ? 16'h0000 : cnt_q;
	wire cnt_halt = final_q & ~cnt_sw_clr;
	wire [15:0] cnt_d = (cnt_pulse && !cnt_halt) ?
		cnt_base + 16'h0001 : cnt_base;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
			final_q <= 1'b0;
			mid_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			final_q <= cnt_d >= final_cnt_q;
			mid_q <= cnt_d >= mid_cnt_q;
		end
	end

	// Length pulses; result in flight is dropped after a clear
	logic [31:0] pulse_q;
	logic len_init_q;
	logic len_stale_q;
	logic len_done;
	logic [35:0] len_quot;
	wire [31:0] pulse_base = len_clr ? 32'h00000000 : pulse_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= 32'h00000000;
			len_init_q <= 1'b1;
			len_stale_q <= 1'b0;
			meas_len_q <= 16'h0000;
			len_reached_q <= 1'b0;
		end else begin
			len_init_q <= 1'b0;
			if (len_pulse && pulse_base != 32'hFFFFFFFF)
				pulse_q <= pulse_base + 32'h00000001;
			else
				pulse_q <= pulse_base;
			if (len_clr) begin
				meas_len_q <= 16'h0000;
				len_stale_q <= 1'b1;
			end else if (len_done) begin
				len_stale_q <= 1'b0;
				if (!len_stale_q)
					meas_len_q <= len_quot[35:16] != '0 ?
						16'hFFFF : len_quot[15:0];
			end
			len_reached_q <= meas_len_q > tgt_len_q;
		end
	end

	seq_divider #(.NW(36), .DW(16)) u_len_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(len_done | len_init_q),
		.num({4'h0, pulse_q} * 36'(LEN_SCALE)),
		.den(ppm_q),
		.done(len_done),
		.quot(len_quot)
	);

	// Millisecond tick for the swing phase
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic tick_d1_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
			tick_d1_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == 32'(MS_TICK_CYCLES - 1);
			tick_d1_q <= tick_q;
			if (tick_cnt_q == 32'(MS_TICK_CYCLES - 1))
				tick_cnt_q <= 32'h00000000;
			else
				tick_cnt_q <= tick_cnt_q + 32'h00000001;
		end
	end

	// Amplitude, jump and ramp times, one register stage each
	logic [15:0] aw_q;
	logic [15:0] jump_q;
	logic [16:0] span_q;
	logic [23:0] rise_ms_q;
	logic [23:0] fall_ms_q;
	wire [15:0] base_f = base_sel_q ? max_freq_q : centre_q;
	wire [31:0] aw_prod = base_f * swing_pct_q;
	wire [31:0] jump_prod = aw_q * jump_pct_q;
	wire [31:0] rise_prod = cycle_q * rise_coef_q;
	wire [31:0] cyc_ms = cycle_q * 32'(MS_PER_CYCLE_UNIT);
	wire [31:0] rise_ms = rise_prod * 32'(MS_PER_CYCLE_UNIT) /
		32'(PCT_SCALE);
	wire active = swing_en_q && swing_pct_q != 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aw_q <= 16'h0000;
			jump_q <= 16'h0000;
			span_q <= 17'h00000;
			rise_ms_q <= 24'h000000;
			fall_ms_q <= 24'h000000;
		end else begin
			aw_q <= 16'(aw_prod / 32'(PCT_SCALE));
			jump_q <= 16'(jump_prod / 32'(PCT_SCALE));
			span_q <= {aw_q, 1'b0} - {1'b0, jump_q};
			rise_ms_q <= rise_ms[23:0];
			fall_ms_q <= 24'(cyc_ms - rise_ms);
		end
	end

	assign sw.tick = tick_q;
	assign sw.run = active;
	assign sw.rise_ms = rise_ms_q;
	assign sw.fall_ms = fall_ms_q;

	swing_phase u_phase (
		.pclk(pclk),
		.presetn(presetn),
		.sw(sw.phase)
	);

	// Ramp position = span * (t + 1) / ramp length
	logic sdiv_done;
	logic [40:0] sdiv_quot;
	logic [16:0] ramp_q;
	logic dir_q;
	wire [23:0] ramp_den = sw.falling ? fall_ms_q : rise_ms_q;
	wire [40:0] ramp_num = span_q * ({17'h00000, sw.t_ms} +
		41'h00000000001);

	seq_divider #(.NW(41), .DW(24)) u_ramp_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(tick_d1_q),
		.num(ramp_num),
		.den(ramp_den),
		.done(sdiv_done),
		.quot(sdiv_quot)
	);

	wire signed [18:0] edge_ofs = $signed({3'b000, aw_q}) -
		$signed({3'b000, jump_q});
	wire signed [18:0] ramp_s = $signed({2'b00, ramp_q});
	wire signed [18:0] ofs = dir_q ? edge_ofs - ramp_s :
		ramp_s - edge_ofs;
	wire signed [18:0] raw_f = active ?
		$signed({3'b000, centre_q}) + ofs : $signed({3'b000, centre_q});
	wire signed [18:0] up_s = $signed({3'b000, upper_q});
	wire signed [18:0] lo_s = $signed({3'b000, lower_q});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_q <= 17'h00000;
			dir_q <= 1'b0;
			output_frequency <= 16'h0000;
		end else begin
			// Direction moves with the ramp value, so a turn never
			// shows the old peak mirrored to the far side
			if (!active || ramp_den == 24'h000000) begin
				ramp_q <= 17'h00000;
				dir_q <= sw.falling;
			end else if (sdiv_done) begin
				ramp_q <= sdiv_quot > {24'h000000, span_q} ?
					span_q : sdiv_quot[16:0];
				dir_q <= sw.falling;
			end
			// limit clamp; upper wins over a crossed lower
			if (raw_f > up_s || lo_s > up_s)
				output_frequency <= upper_q;
			else if (raw_f < lo_s)
				output_frequency <= lower_q;
			else
				output_frequency <= raw_f[15:0];
		end
	end

	// Output terminals follow their assigned function
	for (genvar j = 0; j < NUM_DO; j++) begin : g_do
		wire [FN_W-1:0] fn = do_fn_q[j*FN_W +: FN_W];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				do_terminal[j] <= 1'b0;
			else
				do_terminal[j] <= (fn == FN_FINAL_REACHED && final_q) ||
					(fn == FN_MID_REACHED && mid_q) ||
					(fn == FN_LEN_REACHED && len_reached_q);
		end
	end
endmodule

// ### tb/swing_len_chk.sv
`timescale 1ns/100ps
module swing_len_chk
	import swing_len_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_DI-1:0] digital_input_terminal,
	input wire logic high_speed_pulse_input,
	input wire logic [NUM_DO-1:0] do_terminal,
	input wire logic [15:0] output_frequency
);
	logic [15:0] cen_q, up_q, lo_q, pct_q;
	logic en_q;
	logic [5:0] quiet_q;
	wire wr_ok = psel && penable && pready && pwrite;
	wire [15:0] low_cut = cen_q < lo_q ? lo_q : cen_q;
	wire [15:0] clamped = low_cut > up_q ? up_q : low_cut;
	// Give the output time to follow a new setting before judging it
	wire settled = quiet_q == 6'h3F;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cen_q, lo_q, pct_q, en_q, quiet_q} <= '0;
			up_q <= UPPER_RST;
		end else if (wr_ok) begin
			quiet_q <= 6'h00;
			if (paddr == CENTRE_OFS) cen_q <= pwdata[15:0];
			if (paddr == UPPER_OFS) up_q <= pwdata[15:0];
			if (paddr == LOWER_OFS) lo_q <= pwdata[15:0];
			if (paddr == SWING_PCT_OFS) pct_q <= pwdata[15:0];
			if (paddr == CTRL_OFS) en_q <= pwdata[0];
		end else if (!settled) begin
			quiet_q <= quiet_q + 6'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready && penable ##1 !pready;
	endsequence
	a_ready_setup: assert property (s_setup |=> s_answer)
		else $error("no single ready after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_err_decode: assert property (pready |->
		pslverr == (paddr > DO_FN_OFS || paddr[1:0] != 2'b00))
		else $error("error flag does not match address");
	a_freq_upper: assert property (settled |-> output_frequency <= up_q)
		else $error("output above upper limit");
	a_freq_lower: assert property (settled && lo_q <= up_q |->
		output_frequency >= lo_q)
		else $error("output below lower limit");
	a_swing_idle: assert property (settled && (!en_q || pct_q == 0) |->
		output_frequency == clamped)
		else $error("output moves without swing");
	a_idle_steady: assert property (settled && !en_q |=>
		$stable(output_frequency))
		else $error("output changes while swing off");
endmodule

bind swing_freq_length_counter swing_len_chk u_swing_len_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.digital_input_terminal(digital_input_terminal),
	.high_speed_pulse_input(high_speed_pulse_input),
	.do_terminal(do_terminal), .output_frequency(output_frequency));

// ### tb/pulse_src.sv
`timescale 1ns/100ps
module pulse_src (
	input wire logic pclk,
	output logic [4:0] pins
);
	initial pins = 5'h00;
	// Pulses on chosen terminal
	// At least three cycles each level: clear of the two-flop synchroniser
	task automatic send(input int t, input int n);
		repeat (n) begin
			@(posedge pclk);
			pins[t] <= 1'b1;
			repeat (3) @(posedge pclk);
			pins[t] <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task automatic hold(input int t, input logic v);
		@(posedge pclk);
		pins[t] <= v;
	endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import swing_len_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	logic [4:0] pins;
	logic [3:0] do_terminal;
	logic [15:0] output_frequency, prev, cur, hi, lo;
	int mismatches = 0, checks_done = 0;
	int c, aw, j, up, dn, st, mx, ulim, llim, fc, mc, tl, ppm, k;
	logic [7:0] ra [13] = '{SWING_PCT_OFS, JUMP_PCT_OFS, CYCLE_OFS,
		RISE_COEF_OFS, TGT_LEN_OFS, PPM_OFS, FINAL_CNT_OFS, MID_CNT_OFS,
		MAX_FREQ_OFS, UPPER_OFS, LOWER_OFS, MEAS_LEN_OFS, COUNT_OFS};
	logic [15:0] rv [13] = '{16'h0000, 16'h0000, 16'h0064, 16'h01F4,
		16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h1388, 16'h1388,
		16'h0000, 16'h0000, 16'h0000};
	logic [7:0] sa [9] = '{SWING_PCT_OFS, JUMP_PCT_OFS, CYCLE_OFS,
		RISE_COEF_OFS, PPM_OFS, FINAL_CNT_OFS, MID_CNT_OFS, OUT_FREQ_OFS,
		COUNT_OFS};
	logic [15:0] sw [9] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF};
	logic [15:0] se [9] = '{16'h03E8, 16'h01F4, 16'h7530, 16'h03E8,
		16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000};

	initial begin
		forever #4 pclk = ~pclk;
	end

	swing_freq_length_counter #(.MS_TICK_CYCLES(64))
		u_swing_freq_length_counter (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .digital_input_terminal(pins[3:0]),
		.high_speed_pulse_input(pins[4]), .do_terminal(do_terminal),
		.output_frequency(output_frequency));
	pulse_src u_pulse_src (.pclk(pclk), .pins(pins));

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Waits for pready as long as it takes; only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk(n, 1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	function automatic int clampv(int v, int l, int u);
		int r;
		r = v < l ? l : v;
		return r > u ? u : r;
	endfunction

	function automatic int exp_len(int p, int q);
		return p * 10 / q;
	endfunction

	initial begin
		k = $urandom(85);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
		apb(1'b0, 8'h50, 32'h0);
		chk(rerr, 1);
		chk(rdat, 0);
		for (int i = 0; i < 9; i++) begin
			wr(sa[i], sw[i]);
			rd(sa[i], se[i]);
		end
		wr(DI_FN_OFS, {2'h0, 6'h19, 12'h000, 6'h1C, 6'h1B});
		wr(DO_FN_OFS, {14'h0, 6'h0A, 6'h09, 6'h08});
		fc = 3 + $urandom % 6;
		mc = 2 + $urandom % (fc - 1);
		wr(FINAL_CNT_OFS, fc);
		wr(MID_CNT_OFS, mc);
		u_pulse_src.send(4, mc - 1);
		repeat (5) @(posedge pclk);
		chk(do_terminal[1], 0);
		u_pulse_src.send(4, 1);
		repeat (5) @(posedge pclk);
		chk(do_terminal[1], 1);
		chk(do_terminal[0], mc == fc);
		u_pulse_src.send(4, fc - mc + 2);
		repeat (5) @(posedge pclk);
		chk(do_terminal[0], 1);
		rd(COUNT_OFS, fc);
		ppm = 10 * (1 + $urandom % 3);
		k = ppm / 10;
		tl = 1 + $urandom % 3;
		wr(PPM_OFS, ppm);
		wr(TGT_LEN_OFS, tl);
		u_pulse_src.send(0, tl * k);
		repeat (90) @(posedge pclk);
		rd(MEAS_LEN_OFS, exp_len(tl * k, ppm));
		chk(do_terminal[2], 0);
		u_pulse_src.send(0, k);
		repeat (90) @(posedge pclk);
		rd(MEAS_LEN_OFS, exp_len(tl * k + k, ppm));
		chk(do_terminal[2], 1);
		u_pulse_src.hold(1, 1'b1);
		repeat (8) @(posedge pclk);
		rd(MEAS_LEN_OFS, 0);
		chk(do_terminal[2], 0);
		u_pulse_src.hold(1, 1'b0);
		// The pin clear must also have emptied the pulse tally
		u_pulse_src.send(0, k);
		repeat (90) @(posedge pclk);
		rd(MEAS_LEN_OFS, exp_len(k, ppm));
		// Software clears of length and count together
		wr(CTRL_OFS, 32'h0000000C);
		rd(MEAS_LEN_OFS, 0);
		rd(COUNT_OFS, 0);
		chk(do_terminal[0], 0);
		chk(do_terminal[1], 0);
		c = 1000 + $urandom % 2000;
		wr(CENTRE_OFS, c);
		wr(SWING_PCT_OFS, 100);
		wr(JUMP_PCT_OFS, 100);
		wr(CYCLE_OFS, 1);
		for (int i = 0; i < 3; i++) begin
			aw = (i == 1 ? 5000 : c) / 10;
			j = aw / 10;
			ulim = i == 2 ? c + aw / 2 : 5000;
			llim = i == 2 ? c - aw / 2 : 0;
			wr(UPPER_OFS, ulim);
			wr(LOWER_OFS, llim);
			wr(RISE_COEF_OFS, i == 1 ? 200 : 500);
			wr(CTRL_OFS, {30'h0, i == 1, 1'b1});
			repeat (6400) @(posedge pclk);
			{hi, lo, up, dn, mx} = {16'h0000, 16'hFFFF, 96'h0};
			prev = output_frequency;
			repeat (6400) begin
				@(posedge pclk);
				cur = output_frequency;
				up += cur > prev;
				dn += cur < prev;
				st = cur > prev ? cur - prev : prev - cur;
				mx = st > mx ? st : mx;
				hi = cur > hi ? cur : hi;
				lo = cur < lo ? cur : lo;
				prev = cur;
			end
			chk(hi, clampv(c + aw, llim, ulim));
			chk(lo, clampv(c - aw, llim, ulim));
			if (i < 2) begin
				chk(up, i == 1 ? 20 : 50);
				chk(dn, i == 1 ? 80 : 50);
				chk(mx > j, 1);
			end
		end
		wr(SWING_PCT_OFS, 0);
		repeat (100) @(posedge pclk);
		chk(output_frequency, clampv(c, llim, ulim));
		end_sim();
	end

	initial begin
		repeat (90000) @(posedge pclk);
		mismatches++;
		end_sim();
	end
endmodule
